// *** design/event_status_and_ready_pin.sv ***
`timescale 1ns/1ns
module event_status_and_ready_pin
   import event_status_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [event_status_pkg::ADDR_W-1:0] addr,
   input wire logic [event_status_pkg::DATA_W-1:0] wrData,
   input wire logic wrEn,
   input wire logic rdEn,
   output logic [event_status_pkg::DATA_W-1:0] rdData,
   input wire logic resultValid,
   input wire logic [event_status_pkg::RESULT_W-1:0] resultData,
   input wire logic queueWr,
   input wire logic [3:0] queueWrIdx,
   input wire logic accumDone,
   input wire logic [event_status_pkg::SUM_W-1:0] accumSum,
   input wire logic upperTrip,
   input wire logic lowerTrip,
   input wire logic dvddBelow18,
   input wire logic dvddBelow27,
   input wire logic [7:0] avddBelow,
   input wire logic [3:0] analogPinIn,
   input wire logic [3:0] digitalPinIn,
   output logic [3:0] digitalPinOut,
   output logic [3:0] digitalPinOeN,
   output logic switchTwoCtrl,
   output logic irqOut
);
   import event_status_pkg::*;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [3:0] pinsInMode(input logic [15:0] modes,
                                             input logic [3:0] mode);
      logic [3:0] hit;
      hit = 4'h0;
      for (int i = 0; i < PIN_COUNT; i++) begin
         hit[i] = (modes[4*i +: 4] == mode);
      end
      return hit;
   endfunction

   function automatic logic access(input logic en,
                                   input logic [3:0] a,
                                   input logic [3:0] ofs);
      return en && (a == ofs);
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [23:0] status_ff, nxt_status;
   logic [23:0] mask_ff, nxt_mask;
   logic [15:0] pinMode_ff, nxt_pinMode;
   logic [3:0] pinLevel_ff, nxt_pinLevel;
   logic [2:0] threshSel_ff, nxt_threshSel;
   logic [2:0] monOn_ff, nxt_monOn;
   logic [3:0] fullIdx_ff, nxt_fullIdx;
   logic [RESULT_W-1:0] result_ff, nxt_result;
   logic [SUM_W-1:0] sum_ff, nxt_sum;
   logic convReady_ff, nxt_convReady;
   logic dip_ff, nxt_dip;
   logic [23:0] rdData_ff, nxt_rdData;
   logic [3:0] pinOut_ff, nxt_pinOut;
   logic [3:0] pinOeN_ff, nxt_pinOeN;
   logic switchTwo_ff, nxt_switchTwo;
   logic irq_ff, nxt_irq;

   logic statusRd, dataRd, queueAcc, accumAcc;
   logic upperWr, lowerWr;
   logic [7:0] riseEv, fallEv;
   logic [23:0] events;
   logic [3:0] readyPins, outPins, swPins;

   pin_edge_detect edges (
      .clock(clock),
      .rst_n(rst_n),
      .pinIn({analogPinIn, digitalPinIn}),
      .rise(riseEv),
      .fall(fallEv)
   );

   // ----------------------------------------
   // Access decode
   // ----------------------------------------
   always_comb begin
      statusRd = access(rdEn, addr, OFS_STATUS);
      dataRd = access(rdEn, addr, OFS_CONV_DATA);
      queueAcc = access(rdEn | wrEn, addr, OFS_QUEUE);
      accumAcc = access(rdEn | wrEn, addr, OFS_ACCUM);
      upperWr = access(wrEn, addr, OFS_UPPER_ALARM);
      lowerWr = access(wrEn, addr, OFS_LOWER_ALARM);
   end

   // ----------------------------------------
   // Event collection
   // ----------------------------------------
   always_comb begin
      events = 24'h00_0000;
      // Monitors that are off cannot set their flag
      events[BIT_SUPPLY_A] = dvddBelow18 && monOn_ff[0];
      events[BIT_SUPPLY_B] = dvddBelow27 && monOn_ff[1];
      events[BIT_ANALOG_SUPPLY] = avddBelow[threshSel_ff]
                                  && monOn_ff[2];
      events[BIT_CONV_DONE] = resultValid;
      events[BIT_QUEUE_FULL] = queueWr
                               && (queueWrIdx == fullIdx_ff);
      events[BIT_ACCUM_FULL] = accumDone;
      events[BIT_UPPER_ALARM] = upperTrip;
      events[BIT_LOWER_ALARM] = lowerTrip;
      events[LSB_ANALOG_RISE +: 4] = riseEv[7:4];
      events[LSB_ANALOG_FALL +: 4] = fallEv[7:4];
      events[LSB_DIGITAL_RISE +: 4] = riseEv[3:0];
      events[LSB_DIGITAL_FALL +: 4] = fallEv[3:0];
   end

   // ----------------------------------------
   // Status word and interrupt
   // ----------------------------------------
   always_comb begin
      nxt_status = status_ff;
      if (statusRd) begin
         // Supply flags re-set below while their condition holds
         nxt_status = STATUS_RST;
      end
      if (dataRd) begin
         nxt_status[BIT_CONV_DONE] = 1'b0;
      end
      if (queueAcc) begin
         nxt_status[BIT_QUEUE_FULL] = 1'b0;
      end
      if (accumAcc) begin
         nxt_status[BIT_ACCUM_FULL] = 1'b0;
      end
      if (upperWr) begin
         nxt_status[BIT_UPPER_ALARM] = 1'b0;
      end
      if (lowerWr) begin
         nxt_status[BIT_LOWER_ALARM] = 1'b0;
      end
      // Events in the read cycle land after the clear
      nxt_status = nxt_status | events;
      // Read drops the line unless a fresh unmasked flag arrived
      nxt_irq = |(nxt_status & ~nxt_mask);
   end

   // ----------------------------------------
   // Configuration and data registers
   // ----------------------------------------
   always_comb begin
      nxt_mask = mask_ff;
      nxt_pinMode = pinMode_ff;
      nxt_pinLevel = pinLevel_ff;
      nxt_threshSel = threshSel_ff;
      nxt_monOn = monOn_ff;
      nxt_fullIdx = fullIdx_ff;
      nxt_result = resultValid ? resultData : result_ff;
      // Sum held until the next accumulation overwrites it
      nxt_sum = accumDone ? accumSum : sum_ff;
      if (wrEn) begin
         case (addr)
            OFS_MASK: nxt_mask = wrData;
            OFS_PIN_MODE: nxt_pinMode = wrData[15:0];
            OFS_PIN_LEVEL: nxt_pinLevel = wrData[3:0];
            OFS_MON_CTRL: begin
               nxt_threshSel = wrData[2:0];
               nxt_monOn = wrData[6:4];
               nxt_fullIdx = wrData[11:8];
            end
            default: nxt_mask = mask_ff;
         endcase
      end
   end

   // ----------------------------------------
   // Read data, valid only the cycle after rdEn
   // ----------------------------------------
   always_comb begin
      nxt_rdData = 24'h00_0000;
      if (rdEn) begin
         case (addr)
            OFS_STATUS: nxt_rdData = status_ff;
            OFS_MASK: nxt_rdData = mask_ff;
            OFS_PIN_MODE: nxt_rdData = {8'h00, pinMode_ff};
            // Level read returns the pin, whatever its mode
            OFS_PIN_LEVEL: nxt_rdData = {20'h0_0000, digitalPinIn};
            OFS_CONV_DATA: nxt_rdData = {8'h00, result_ff};
            OFS_ACCUM: nxt_rdData = {4'h0, sum_ff};
            OFS_MON_CTRL: nxt_rdData = {12'h000, fullIdx_ff, 1'b0,
                                        monOn_ff, 1'b0, threshSel_ff};
            default: nxt_rdData = 24'h00_0000;
         endcase
      end
   end

   // ----------------------------------------
   // Conversion-ready and pin drive
   // ----------------------------------------
   always_comb begin
      readyPins = pinsInMode(pinMode_ff, MODE_CONV_READY);
      outPins = pinsInMode(pinMode_ff, MODE_GENERAL_OUT);
      swPins = pinsInMode(pinMode_ff, MODE_SWITCH_TWO);
      // A new result wins over a same-cycle read
      if (resultValid) begin
         nxt_convReady = 1'b1;
      end else if (statusRd || dataRd) begin
         nxt_convReady = 1'b0;
      end else begin
         nxt_convReady = convReady_ff;
      end
      nxt_dip = resultValid && convReady_ff;
      nxt_pinOut = 4'h0;
      nxt_pinOeN = 4'hF;
      for (int i = 0; i < PIN_COUNT; i++) begin
         if (readyPins[i]) begin
            nxt_pinOut[i] = nxt_convReady && !nxt_dip;
            nxt_pinOeN[i] = 1'b0;
         end else if (outPins[i]) begin
            nxt_pinOut[i] = pinLevel_ff[i];
            nxt_pinOeN[i] = 1'b0;
         end
      end
      // Several pins in this mode act as a wired OR
      nxt_switchTwo = |(swPins & digitalPinIn);
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Supply flags start at zero; host reads status after power-up
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         status_ff <= STATUS_RST;
         mask_ff <= MASK_RST;
         pinMode_ff <= PIN_MODE_RST;
         pinLevel_ff <= PIN_LEVEL_RST;
         threshSel_ff <= THRESH_SEL_RST;
         monOn_ff <= MON_ON_RST;
         fullIdx_ff <= FULL_IDX_RST;
         result_ff <= '0;
         sum_ff <= '0;
         convReady_ff <= 1'b0;
         dip_ff <= 1'b0;
         rdData_ff <= 24'h00_0000;
         pinOut_ff <= 4'h0;
         pinOeN_ff <= 4'hF;
         switchTwo_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         status_ff <= nxt_status;
         mask_ff <= nxt_mask;
         pinMode_ff <= nxt_pinMode;
         pinLevel_ff <= nxt_pinLevel;
         threshSel_ff <= nxt_threshSel;
         monOn_ff <= nxt_monOn;
         fullIdx_ff <= nxt_fullIdx;
         result_ff <= nxt_result;
         sum_ff <= nxt_sum;
         convReady_ff <= nxt_convReady;
         dip_ff <= nxt_dip;
         rdData_ff <= nxt_rdData;
         pinOut_ff <= nxt_pinOut;
         pinOeN_ff <= nxt_pinOeN;
         switchTwo_ff <= nxt_switchTwo;
         irq_ff <= nxt_irq;
      end
   end

   always_comb begin
      rdData = rdData_ff;
      digitalPinOut = pinOut_ff;
      digitalPinOeN = pinOeN_ff;
      switchTwoCtrl = switchTwo_ff;
      irqOut = irq_ff;
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   ready_set_a: assert property (resultValid |=> convReady_ff)
      else $error("ready not set after result");
   ready_clear_a: assert property (
      (statusRd || dataRd) && !resultValid |=> !convReady_ff)
      else $error("ready not cleared by read");
   ready_dip_a: assert property (
      resultValid && convReady_ff && readyPins[1] && !wrEn
      ##1 (!resultValid && !statusRd && !dataRd && !wrEn)
      |-> !digitalPinOut[1] ##1 digitalPinOut[1])
      else $error("ready dip wrong");
   dip_pin_low_a: assert property (
      dip_ff && $past(readyPins[1]) |-> !digitalPinOut[1]
                                      && !digitalPinOeN[1])
      else $error("ready pin not low during dip");
   gpo_level_a: assert property (
      outPins[0] |=> digitalPinOut[0] == $past(pinLevel_ff[0])
                     && !digitalPinOeN[0])
      else $error("general output level wrong");
   irq_mask_a: assert property (
      irqOut == |(status_ff & ~mask_ff))
      else $error("interrupt disagrees with flags");
   flag_hold_a: assert property (
      !statusRd |=> (status_ff[15:0] & $past(status_ff[15:0]))
                    == $past(status_ff[15:0]))
      else $error("edge flag lost without read");
   read_clear_a: assert property (
      statusRd && events == 24'h00_0000 |=> status_ff == 24'h00_0000)
      else $error("status not cleared by read");
   read_data_a: assert property (
      statusRd |=> rdData == $past(status_ff))
      else $error("status read data wrong");
   supply_keep_a: assert property (
      statusRd && dvddBelow18 && monOn_ff[0] |=> status_ff[BIT_SUPPLY_A])
      else $error("supply flag cleared while low");
   supply_off_a: assert property (
      !monOn_ff[1] && !statusRd
      |=> status_ff[BIT_SUPPLY_B] == $past(status_ff[BIT_SUPPLY_B]))
      else $error("powered-down monitor flag changed");
   queue_full_a: assert property (
      queueWr && queueWrIdx == fullIdx_ff |=> status_ff[BIT_QUEUE_FULL])
      else $error("queue full flag not set");

   read_during_event_c: cover property (statusRd && events != 24'h00_0000);
   ready_dip_c: cover property (resultValid && convReady_ff && readyPins[1]);
   irq_release_c: cover property (irqOut ##1 !irqOut);
   edge_flag_c: cover property (riseEv[0] ##[1:10] fallEv[0]);
endmodule

// *** design/event_status_pkg.sv ***
package event_status_pkg;
   // ----------------------------------------
   // Register port
   // ----------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 24;
   localparam logic [3:0] OFS_STATUS = 4'h0;
   localparam logic [3:0] OFS_MASK = 4'h1;
   localparam logic [3:0] OFS_PIN_MODE = 4'h2;
   localparam logic [3:0] OFS_PIN_LEVEL = 4'h3;
   localparam logic [3:0] OFS_CONV_DATA = 4'h4;
   localparam logic [3:0] OFS_QUEUE = 4'h5;
   localparam logic [3:0] OFS_ACCUM = 4'h6;
   localparam logic [3:0] OFS_UPPER_ALARM = 4'h7;
   localparam logic [3:0] OFS_LOWER_ALARM = 4'h8;
   localparam logic [3:0] OFS_MON_CTRL = 4'h9;

   // ----------------------------------------
   // Status word layout
   // ----------------------------------------
   localparam int BIT_SUPPLY_A = 23;
   localparam int BIT_SUPPLY_B = 22;
   localparam int BIT_ANALOG_SUPPLY = 21;
   localparam int BIT_CONV_DONE = 20;
   localparam int BIT_QUEUE_FULL = 19;
   localparam int BIT_ACCUM_FULL = 18;
   localparam int BIT_UPPER_ALARM = 17;
   localparam int BIT_LOWER_ALARM = 16;
   localparam int LSB_ANALOG_RISE = 12;
   localparam int LSB_ANALOG_FALL = 8;
   localparam int LSB_DIGITAL_RISE = 4;
   localparam int LSB_DIGITAL_FALL = 0;
   localparam int PIN_COUNT = 4;
   localparam int EDGE_BITS = 16;

   // ----------------------------------------
   // Reset values and field widths
   // ----------------------------------------
   localparam logic [23:0] STATUS_RST = 24'h00_0000;
   localparam logic [23:0] MASK_RST = 24'hFF_FFFF;
   localparam logic [15:0] PIN_MODE_RST = 16'h0000;
   localparam logic [3:0] PIN_LEVEL_RST = 4'h0;
   localparam logic [2:0] THRESH_SEL_RST = 3'h0;
   localparam logic [2:0] MON_ON_RST = 3'h7;
   localparam logic [3:0] FULL_IDX_RST = 4'hF;
   localparam int RESULT_W = 16;
   localparam int SUM_W = 20;
   // Ready output dips for this many master clock cycles on update
   localparam int DIP_CYCLES = 1;

   // ----------------------------------------
   // Pin modes handled here
   // ----------------------------------------
   localparam logic [3:0] MODE_SWITCH_TWO = 4'hD;
   localparam logic [3:0] MODE_CONV_READY = 4'hE;
   localparam logic [3:0] MODE_GENERAL_OUT = 4'hF;
endpackage

// *** design/pin_edge_detect.sv ***
`timescale 1ns/1ns
module pin_edge_detect
   import event_status_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] pinIn,
   output logic [7:0] rise,
   output logic [7:0] fall
);
   logic [7:0] prev_ff;
   logic [7:0] nxt_prev;
   logic armed_ff;
   logic nxt_armed;

   // ----------------------------------------
   // Previous level, armed after first sample
   // ----------------------------------------
   // Arming avoids a false edge from the reset value of prev_ff
   always_comb begin
      nxt_prev = pinIn;
      nxt_armed = 1'b1;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         prev_ff <= 8'h00;
         armed_ff <= 1'b0;
      end else begin
         prev_ff <= nxt_prev;
         armed_ff <= nxt_armed;
      end
   end

   // One pulse per edge on the internal clock
   always_comb begin
      rise = armed_ff ? (pinIn & ~prev_ff) : 8'h00;
      fall = armed_ff ? (~pinIn & prev_ff) : 8'h00;
   end
endmodule

// *** verif/host_model.sv ***
`timescale 1ns/1ns
module host_model
   import event_status_pkg::*;
(
   input wire logic clock,
   output logic [event_status_pkg::ADDR_W-1:0] addr,
   output logic [event_status_pkg::DATA_W-1:0] wrData,
   output logic wrEn,
   output logic rdEn,
   input wire logic [event_status_pkg::DATA_W-1:0] rdData
);
   initial begin
      addr = 4'h0;
      wrData = 24'h00_0000;
      wrEn = 1'b0;
      rdEn = 1'b0;
   end

   // Released bus flips, so a stale address never looks valid
   task automatic idle();
      addr <= ~addr;
      wrData <= ~wrData;
      wrEn <= 1'b0;
      rdEn <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [23:0] d);
      @(posedge clock);
      addr <= a;
      wrData <= d;
      wrEn <= 1'b1;
      @(posedge clock);
      idle();
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [23:0] d);
      @(posedge clock);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clock);
      idle();
      @(negedge clock);
      d = rdData;
   endtask
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ns
module testbench;
   import event_status_pkg::*;
   logic clock, rst_n, wrEn, rdEn, resultValid, queueWr, accumDone;
   logic upperTrip, lowerTrip, dvddBelow18, dvddBelow27, switchTwoCtrl;
   logic irqOut;
   logic [3:0] addr, queueWrIdx, analogPinIn, digitalPinIn;
   logic [3:0] digitalPinOut, digitalPinOeN;
   logic [23:0] wrData, rdData, d;
   logic [15:0] resultData;
   logic [19:0] accumSum;
   logic [7:0] avddBelow;
   int fails, n_tests;

   event_status_and_ready_pin u_dut (.clock(clock), .rst_n(rst_n),
      .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
      .rdData(rdData), .resultValid(resultValid),
      .resultData(resultData), .queueWr(queueWr),
      .queueWrIdx(queueWrIdx), .accumDone(accumDone),
      .accumSum(accumSum), .upperTrip(upperTrip),
      .lowerTrip(lowerTrip), .dvddBelow18(dvddBelow18),
      .dvddBelow27(dvddBelow27), .avddBelow(avddBelow),
      .analogPinIn(analogPinIn), .digitalPinIn(digitalPinIn),
      .digitalPinOut(digitalPinOut), .digitalPinOeN(digitalPinOeN),
      .switchTwoCtrl(switchTwoCtrl), .irqOut(irqOut));

   host_model u_host (.clock(clock), .addr(addr), .wrData(wrData),
      .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask

   task automatic rs(input logic [3:0] a, input logic [23:0] exp);
      u_host.rd(a, d);
      chk(d, exp);
   endtask

   // Bits: result, queue, accum, upper, lower
   task automatic fire(input logic [4:0] ev);
      @(posedge clock);
      {resultValid, queueWr, accumDone, upperTrip, lowerTrip} <= ev;
      @(posedge clock);
      {resultValid, queueWr, accumDone, upperTrip, lowerTrip} <= 5'h0;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_power_up();
      rs(OFS_MASK, 24'hFF_FFFF);
      rs(OFS_STATUS, 24'hC0_0000);
      rs(OFS_STATUS, 24'hC0_0000);
      @(posedge clock) {dvddBelow18, dvddBelow27} <= 2'h0;
      rs(OFS_STATUS, 24'hC0_0000);
      rs(OFS_STATUS, 24'h00_0000);
   endtask

   task automatic t_supply();
      u_host.wr(OFS_MON_CTRL, 24'h00_0F05);
      @(posedge clock) dvddBelow18 <= 1'b1;
      @(posedge clock) avddBelow <= 8'h20;
      rs(OFS_STATUS, 24'h00_0000);
      u_host.wr(OFS_MON_CTRL, 24'h00_0F75);
      rs(OFS_STATUS, 24'hA0_0000);
      @(posedge clock) avddBelow <= 8'h08;
      @(posedge clock) dvddBelow18 <= 1'b0;
      rs(OFS_STATUS, 24'hA0_0000);
      rs(OFS_STATUS, 24'h00_0000);
      @(posedge clock) avddBelow <= 8'h00;
   endtask

   task automatic t_flags();
      @(posedge clock) queueWrIdx <= 4'h3;
      fire(5'h08);
      rs(OFS_STATUS, 24'h00_0000);
      @(posedge clock) queueWrIdx <= 4'hF;
      fire(5'h1F);
      rs(OFS_STATUS, 24'h1F_0000);
      rs(OFS_STATUS, 24'h00_0000);
   endtask

   task automatic t_clears();
      @(posedge clock) resultData <= 16'h1234;
      @(posedge clock) accumSum <= 20'hA_BCDE;
      fire(5'h1F);
      rs(OFS_CONV_DATA, 24'h00_1234);
      u_host.wr(OFS_QUEUE, 24'h00_0000);
      rs(OFS_ACCUM, 24'h0A_BCDE);
      rs(OFS_STATUS, 24'h03_0000);
      fire(5'h03);
      u_host.wr(OFS_UPPER_ALARM, 24'h00_0000);
      rs(OFS_STATUS, 24'h01_0000);
   endtask

   task automatic t_edges();
      @(posedge clock) {analogPinIn, digitalPinIn} <= 8'h81;
      repeat (4) @(posedge clock);
      rs(OFS_STATUS, 24'h00_8010);
      rs(OFS_STATUS, 24'h00_0000);
      @(posedge clock) {analogPinIn, digitalPinIn} <= 8'h00;
      repeat (4) @(posedge clock);
      rs(OFS_STATUS, 24'h00_0801);
   endtask

   task automatic t_irq();
      u_host.wr(OFS_MASK, 24'hEF_FFFF);
      rs(OFS_MASK, 24'hEF_FFFF);
      fire(5'h02);
      @(negedge clock) chk({23'h0, irqOut}, 24'h00_0000);
      fire(5'h10);
      @(negedge clock) chk({23'h0, irqOut}, 24'h00_0001);
      fire(5'h10);
      @(negedge clock) chk({23'h0, irqOut}, 24'h00_0001);
      rs(OFS_STATUS, 24'h12_0000);
      chk({23'h0, irqOut}, 24'h00_0000);
      fork
         rs(OFS_STATUS, 24'h00_0000);
         fire(5'h10);
      join
      chk({23'h0, irqOut}, 24'h00_0001);
      rs(OFS_STATUS, 24'h10_0000);
      u_host.wr(OFS_MASK, 24'hFF_FFFF);
   endtask

   task automatic t_pins();
      u_host.wr(OFS_PIN_MODE, 24'h00_0DEF);
      u_host.wr(OFS_PIN_LEVEL, 24'h00_0001);
      // Pin drive follows the level register one cycle later
      repeat (2) @(negedge clock);
      chk({19'h0, digitalPinOeN, digitalPinOut[0]}, 24'h00_0019);
      chk({23'h0, switchTwoCtrl}, 24'h00_0000);
      u_host.wr(OFS_PIN_LEVEL, 24'h00_0000);
      repeat (2) @(negedge clock);
      chk({23'h0, digitalPinOut[0]}, 24'h00_0000);
      @(posedge clock) digitalPinIn <= 4'h4;
      repeat (2) @(posedge clock);
      @(negedge clock) chk({23'h0, switchTwoCtrl}, 24'h00_0001);
      fire(5'h10);
      repeat (2) @(posedge clock);
      @(negedge clock) chk({23'h0, digitalPinOut[1]}, 24'h1);
      fire(5'h10);
      @(negedge clock) chk({23'h0, digitalPinOut[1]}, 24'h0);
      @(negedge clock) chk({23'h0, digitalPinOut[1]}, 24'h1);
      u_host.rd(OFS_CONV_DATA, d);
      @(negedge clock) chk({23'h0, digitalPinOut[1]}, 24'h0);
      fire(5'h10);
      repeat (2) @(posedge clock);
      u_host.rd(OFS_STATUS, d);
      @(negedge clock) chk({23'h0, digitalPinOut[1]}, 24'h0);
   endtask

   // ----------------------------------------
   // Clock, reset, sequence, watchdog
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   initial begin
      repeat (5000) @(posedge clock);
      fails++;
      report_and_stop();
   end

   initial begin
      fails = 0;
      n_tests = 0;
      rst_n = 1'b0;
      {resultValid, queueWr, accumDone, upperTrip, lowerTrip} = 5'h0;
      resultData = 16'h0000;
      queueWrIdx = 4'hF;
      accumSum = 20'h0_0000;
      // Both digital supplies start low, as at power-up; the analog supply starts above every threshold
      dvddBelow18 = 1'b1;
      dvddBelow27 = 1'b1;
      avddBelow = 8'h00;
      analogPinIn = 4'h0;
      digitalPinIn = 4'h0;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      @(negedge clock) chk({19'h0, digitalPinOeN, irqOut}, 24'h1E);
      t_power_up();
      t_supply();
      t_flags();
      t_clears();
      t_edges();
      t_irq();
      t_pins();
      report_and_stop();
   end
endmodule
